// file: fbw_ctrl.sv
// Flash block write controller with AXI4-Lite register access
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module fbw_ctrl
  import fbw_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int POR_CYCLES = POR_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic instr_retire,
  output logic instr_squash,
  output logic cpu_halt,
  output var fbw_flash_s flash,
  input wire fbw_ext_s ext,
  output logic ext_grant,
  output logic ext_refuse
);
  fbw_state_e state;
  fbw_state_e next_state;
  fbw_words_s words;
  logic [8:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane;
  logic aw_have;
  logic w_have;
  logic do_write;
  logic [7:0] val_lo;
  logic [5:0] val_hi;
  logic [7:0] adr_lo;
  logic [3:0] adr_hi;
  logic target;
  logic erase;
  logic fault;
  logic permit;
  logic go_bit;
  logic short_pend;
  logic done_flag;
  logic done_en;
  logic [7:0] config_reg;
  logic [1:0] lock_st;
  logic por_done;
  logic [31:0] por_cnt;
  logic [31:0] prog_cnt;
  logic go_req;
  logic go_ok;
  logic writable;
  logic prog_end;
  logic [11:0] word_addr;
  logic [11:0] prot_top;
  logic mapped_rd;
  logic [7:0] rd_byte;

  assign word_addr = {adr_hi, adr_lo};
  assign do_write = aw_have && w_have && !s_axi_bvalid;
  assign prog_end = state == ST_PROG && prog_cnt == 32'(PROG_CYCLES - 1);

  // AXI write address and data, taken in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_idx <= 9'h000;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_idx <= s_axi_awaddr[ADDR_W-1:2];
      end else if (!aw_have && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end else if (!w_have && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic mapped(input logic [8:0] idx);
    mapped = idx inside {IDX_FLAGS2, IDX_ENABLE2, IDX_VAL_LO, IDX_ADR_LO, IDX_VAL_HI,
                         IDX_ADR_HI, IDX_CTRL, IDX_UNLOCK, IDX_CONFIG};
  endfunction

  // Only the low byte lane carries register data
  function automatic logic hit(input logic [8:0] idx);
    hit = do_write && w_lane && aw_idx == idx;
  endfunction

  // Plain data registers
  always_ff @(posedge clk) begin
    if (rst) begin
      val_lo <= 8'h00;
      val_hi <= 6'h00;
      adr_lo <= 8'h00;
      adr_hi <= 4'h0;
      done_en <= 1'b0;
      config_reg <= CONFIG_RST;
    end else if (ce) begin
      if (hit(IDX_VAL_LO)) val_lo <= w_byte;
      if (hit(IDX_VAL_HI)) val_hi <= w_byte[5:0];
      if (hit(IDX_ADR_LO)) adr_lo <= w_byte;
      if (hit(IDX_ADR_HI)) adr_hi <= w_byte[3:0];
      if (hit(IDX_ENABLE2)) done_en <= w_byte[FB_DONE];
      if (hit(IDX_CONFIG)) config_reg <= w_byte;
    end
  end

  // Unlock tracker: any other write breaks the sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_st <= 2'd0;
    end else if (ce && do_write) begin
      if (hit(IDX_UNLOCK) && w_byte == UNLOCK_A) begin
        lock_st <= 2'd1;
      end else if (hit(IDX_UNLOCK) && w_byte == UNLOCK_B && lock_st == 2'd1) begin
        lock_st <= 2'd2;
      end else begin
        lock_st <= 2'd0;
      end
    end
  end

  // Power-up timer, guards against writes while supplies settle
  always_ff @(posedge clk) begin
    if (rst) begin
      por_cnt <= 32'h0000_0000;
      por_done <= 1'b0;
    end else if (ce && !por_done) begin
      por_cnt <= por_cnt + 32'h0000_0001;
      if (por_cnt == 32'(POR_CYCLES - 1)) por_done <= 1'b1;
    end
  end

  always_comb begin
    case (config_reg[CFG_PROT +: 2])
      2'b00: prot_top = PROT_TOP_ALL;
      2'b01: prot_top = PROT_TOP_HALF;
      2'b10: prot_top = PROT_TOP_LOW;
      default: prot_top = 12'h000;
    endcase
  end
  // Region starts at word zero; setting 11 leaves everything writable
  assign writable = config_reg[CFG_PROT +: 2] == 2'b11 || word_addr > prot_top;

  // Old permit is checked, so enabling and go in one write is refused
  assign go_req = hit(IDX_CTRL) && w_byte[CB_GO] && !go_bit && state == ST_IDLE;
  assign go_ok = go_req && permit && lock_st == 2'd2 && por_done
    && target && !erase;

  // Control register
  always_ff @(posedge clk) begin
    if (rst) begin
      target <= 1'b0;
      erase <= 1'b0;
      fault <= 1'b0;
      permit <= 1'b0;
      go_bit <= 1'b0;
      short_pend <= 1'b0;
    end else if (ce) begin
      short_pend <= 1'b0;
      if (hit(IDX_CTRL)) begin
        target <= w_byte[CB_TARGET];
        erase <= w_byte[CB_ERASE];
        permit <= w_byte[CB_PERMIT];
        if (!w_byte[CB_FAULT]) fault <= 1'b0;
      end
      if (go_ok && !writable) begin
        fault <= 1'b1;
      end else if (go_ok) begin
        go_bit <= 1'b1;
        short_pend <= adr_lo[1:0] != LAST_SLOT;
      end
      if (short_pend) go_bit <= 1'b0;
      if (prog_end) go_bit <= 1'b0;
    end
  end

  // Done flag: hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      done_flag <= 1'b0;
    end else if (ce) begin
      if (prog_end) begin
        done_flag <= 1'b1;
      end else if (hit(IDX_FLAGS2)) begin
        done_flag <= w_byte[FB_DONE];
      end
    end
  end

  fbw_stage u_stage (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(go_ok && writable),
    .slot(adr_lo[1:0]),
    .din({val_hi, val_lo}),
    .blank(prog_end),
    .words(words)
  );

  // Long write sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (go_ok && writable && adr_lo[1:0] == LAST_SLOT) next_state = ST_EXEC;
      ST_EXEC: if (instr_retire) next_state = ST_SKIP;
      ST_SKIP: if (instr_retire) next_state = ST_PROG;
      ST_PROG: if (prog_end) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      instr_squash <= 1'b0;
      cpu_halt <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      instr_squash <= next_state == ST_SKIP;
      cpu_halt <= next_state == ST_PROG;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prog_cnt <= 32'h0000_0000;
    end else if (ce) begin
      prog_cnt <= state == ST_PROG ? prog_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // Flash array command, block index drops the two offset bits
  always_ff @(posedge clk) begin
    if (rst) begin
      flash <= '0;
    end else if (ce) begin
      flash.active <= next_state == ST_PROG;
      if (state == ST_SKIP && next_state == ST_PROG) begin
        flash.block <= word_addr[11:2];
        flash.data <= words;
      end
    end
  end

  // External programmer gate
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_grant <= 1'b0;
      ext_refuse <= 1'b0;
    end else if (ce) begin
      ext_refuse <= ext.req && ((config_reg[CFG_CP_DATA] && (!ext.prog || ext.wr))
        || (config_reg[CFG_CP_PROG] && ext.prog));
      ext_grant <= ext.req && !((config_reg[CFG_CP_DATA] && (!ext.prog || ext.wr))
        || (config_reg[CFG_CP_PROG] && ext.prog));
    end
  end

  // Read channel
  always_comb begin
    mapped_rd = 1'b1;
    case (s_axi_araddr[ADDR_W-1:2])
      IDX_FLAGS2: rd_byte = FLAGS2_RST | (8'(done_flag) << FB_DONE);
      IDX_ENABLE2: rd_byte = ENABLE2_RST | (8'(done_en) << FB_DONE);
      IDX_VAL_LO: rd_byte = val_lo;
      IDX_VAL_HI: rd_byte = {2'b00, val_hi};
      IDX_ADR_LO: rd_byte = adr_lo;
      IDX_ADR_HI: rd_byte = {4'h0, adr_hi};
      IDX_CTRL: rd_byte = {target, 2'b00, erase, fault, permit, go_bit, 1'b0};
      IDX_CONFIG: rd_byte = config_reg;
      IDX_UNLOCK: rd_byte = 8'h00;
      default: begin
        rd_byte = 8'h00;
        mapped_rd = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= mapped_rd ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  a_go_permit: assert property (@(posedge clk) disable iff (rst)
    $rose(go_bit) |-> $past(permit) && $past(ce))
    else $error("go set without permit");
  a_go_unlock: assert property (@(posedge clk) disable iff (rst)
    $rose(go_bit) |-> $past(lock_st) == 2'd2)
    else $error("go set without unlock");
  a_go_por: assert property (@(posedge clk) disable iff (rst)
    $rose(go_bit) |-> $past(por_done))
    else $error("go set during power-up");
  a_short_clear: assert property (@(posedge clk) disable iff (rst)
    $rose(go_bit) && $past(adr_lo[1:0]) != LAST_SLOT && ce |=> !go_bit)
    else $error("short write go not cleared");
  a_prot_block: assert property (@(posedge clk) disable iff (rst)
    $rose(go_bit) |-> writable)
    else $error("write into protected region");
  a_halt_entry: assert property (@(posedge clk) disable iff (rst)
    $rose(cpu_halt) |-> $past(state) == ST_SKIP && flash.active)
    else $error("halt without skipped instruction");
  a_squash_first: assert property (@(posedge clk) disable iff (rst)
    $rose(cpu_halt) |-> $past(instr_squash) && !instr_squash)
    else $error("halt without squashed instruction");
  a_halt_hold: assert property (@(posedge clk) disable iff (rst)
    $rose(cpu_halt) && PROG_CYCLES > 8 |-> cpu_halt[*8])
    else $error("halt too short");
  a_done_end: assert property (@(posedge clk) disable iff (rst)
    $fell(cpu_halt) |-> done_flag && !go_bit)
    else $error("done flag missing at write end");
  a_blank_end: assert property (@(posedge clk) disable iff (rst)
    $fell(cpu_halt) |-> words == {4{BLANK_WORD}})
    else $error("buffers not blanked");
  a_ext_cp: assert property (@(posedge clk) disable iff (rst)
    ce && ext.req && ext.prog && config_reg[CFG_CP_PROG] |=> ext_refuse && !ext_grant)
    else $error("external access not refused");
endmodule // fbw_ctrl
`default_nettype wire

// file: fbw_pkg.sv
// Constants, types and register map of the flash block write controller
package fbw_pkg;
  localparam int ADDR_W = 11;
  localparam logic [8:0] IDX_FLAGS2 = 9'h00d;
  localparam logic [8:0] IDX_ENABLE2 = 9'h08d;
  localparam logic [8:0] IDX_VAL_LO = 9'h10c;
  localparam logic [8:0] IDX_ADR_LO = 9'h10d;
  localparam logic [8:0] IDX_VAL_HI = 9'h10e;
  localparam logic [8:0] IDX_ADR_HI = 9'h10f;
  localparam logic [8:0] IDX_CTRL = 9'h18c;
  localparam logic [8:0] IDX_UNLOCK = 9'h18d;
  localparam logic [8:0] IDX_CONFIG = 9'h1f0;
  localparam int CB_TARGET = 7;
  localparam int CB_ERASE = 4;
  localparam int CB_FAULT = 3;
  localparam int CB_PERMIT = 2;
  localparam int CB_GO = 1;
  localparam int FB_DONE = 4;
  localparam int CFG_PROT = 0;
  localparam int CFG_CP_DATA = 2;
  localparam int CFG_CP_PROG = 3;
  localparam logic [7:0] FLAGS2_RST = 8'h00;
  localparam logic [7:0] ENABLE2_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h03;
  localparam logic [7:0] UNLOCK_A = 8'h55;
  localparam logic [7:0] UNLOCK_B = 8'haa;
  localparam logic [1:0] LAST_SLOT = 2'b11;
  localparam logic [13:0] BLANK_WORD = 14'h3fff;
  localparam logic [11:0] PROT_TOP_ALL = 12'hfff;
  localparam logic [11:0] PROT_TOP_HALF = 12'h7ff;
  localparam logic [11:0] PROT_TOP_LOW = 12'h0ff;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int CLK_MHZ = 250;
  localparam int PROG_TIME_US = 2000;
  localparam int POR_TIME_MS = 72;
  localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int POR_CYC = POR_TIME_MS * 1000 * CLK_MHZ;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_SKIP = 3'b010,
    ST_PROG = 3'b011
  } fbw_state_e;
  typedef struct packed {
    logic [3:0][13:0] word;
  } fbw_words_s;
  typedef struct packed {
    logic active;
    logic [9:0] block;
    fbw_words_s data;
  } fbw_flash_s;
  typedef struct packed {
    logic req;
    logic wr;
    logic prog;
  } fbw_ext_s;
endpackage

// file: fbw_stage.sv
// Four-entry staging buffer for one program block
`timescale 1ns/1ns
`default_nettype none
module fbw_stage
  import fbw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [1:0] slot,
  input wire logic [13:0] din,
  input wire logic blank,
  output var fbw_words_s words
);
  // One element per process, so no variable has two writers
  logic [13:0] entry [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_entry
      always_ff @(posedge clk) begin
        if (rst) begin
          entry[g] <= BLANK_WORD;
        end else if (ce) begin
          if (blank) begin
            entry[g] <= BLANK_WORD;
          end else if (load && slot == 2'(g)) begin
            entry[g] <= din;
          end
        end
      end
    end
  endgenerate
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      words.word[i] = entry[i];
    end
  end
endmodule // fbw_stage
`default_nettype wire

// file: fbw_cpu_model.sv
// Processor core stand-in that retires instructions toward the write controller
`timescale 1ns/1ns
`default_nettype none
module fbw_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic cpu_halt,
  output logic instr_retire
);
  logic ph;
  // Slow mode retires every other cycle, so the controller cannot assume a rate
  always_ff @(posedge clk) begin
    if (rst) begin
      ph <= 1'b0;
    end else begin
      ph <= slow ? ~ph : 1'b1;
    end
  end
  // Nothing completes while the core is stalled for programming
  assign instr_retire = ph && !cpu_halt && !rst;
endmodule // fbw_cpu_model
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the flash block write controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import fbw_pkg::*;
  localparam int PROG = 20;
  localparam int POR = 64;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp, c;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, retire, halt, grant, refuse, act_q;
  logic slow = 1'b0;
  logic squash;
  logic sq_q = 1'b0;
  fbw_flash_s flash;
  fbw_ext_s ext = '0;
  fbw_words_s wd;
  logic [9:0] blk;
  logic [2:0] x;
  logic [7:0] bad_ctl[4] = '{8'h80, 8'h04, 8'h94, 8'h84};
  logic [7:0] bad_ul[4] = '{8'h55, 8'h55, 8'h55, 8'h54};
  logic [17:0] rq[$];
  logic [17:0] e;
  logic [1:0] bq[$];
  logic [1:0] eq[$];
  logic [65:0] fq[$];
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int hcnt = 0;

  always #2 clk = ~clk;

  fbw_ctrl #(.PROG_CYCLES(PROG), .POR_CYCLES(POR)) fbw_ctrl_i (
    .clk(clk), .rst(rst), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .instr_retire(retire), .instr_squash(squash), .cpu_halt(halt), .flash(flash),
    .ext(ext), .ext_grant(grant), .ext_refuse(refuse));

  fbw_cpu_model fbw_cpu_model_i (.clk(clk), .rst(rst), .slow(slow), .cpu_halt(halt),
    .instr_retire(retire));

  task automatic chk(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      $display("BAD %0t %s", $time, what);
      bad_count++;
    end
  endtask

  task automatic tally_and_finish();
    // Expectations never consumed mean a result went missing
    bad_count += rq.size() + bq.size() + fq.size() + eq.size();
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Observer: every result that appears consumes the oldest note
  always @(posedge clk) begin
    cyc <= cyc + 1;
    act_q <= flash.active;
    hcnt <= halt ? hcnt + 1 : 0;
    sq_q <= squash;
    if (halt && hcnt == 0) chk(sq_q === 1'b1 && squash === 1'b0, "squash before halt");
    if (bvalid && bready) begin
      chk(bq.size() > 0 && bresp === bq[0], "write response");
      if (bq.size() > 0) void'(bq.pop_front());
    end
    if (rvalid && rready) begin
      e = rq.size() > 0 ? rq.pop_front() : 'x;
      chk(rresp === e[17:16] && rdata[31:8] === 24'h0 && (rdata[7:0] & e[15:8]) === e[7:0],
          "read data");
    end
    if (flash.active && act_q === 1'b0) begin
      chk(fq.size() > 0 && {flash.block, flash.data} === fq[0], "block commit");
      if (fq.size() > 0) void'(fq.pop_front());
    end
    if (!halt && hcnt != 0) chk(hcnt == PROG, "halt length");
    if (grant || refuse) begin
      chk(eq.size() > 0 && {grant, refuse} === eq[0], "external access");
      if (eq.size() > 0) void'(eq.pop_front());
    end
    if (cyc == 30000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic wr(input logic [8:0] idx, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    bq.push_back(r);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready && !ad) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (wready && !dd) begin
        wvalid <= 1'b0;
        dd = 1'b1;
      end
    end while (!(ad && dd));
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] idx, input logic [7:0] d, input logic [7:0] m,
                    input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, m, d & m});
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // Firmware word sequence: address, data, control, unlock pair, go
  task automatic word_go(input logic [11:0] a, input logic [13:0] d, input logic [7:0] ct,
                         input logic [7:0] u);
    wr(IDX_ADR_HI, {4'h0, a[11:8]});
    wr(IDX_ADR_LO, a[7:0]);
    wr(IDX_VAL_HI, {2'b00, d[13:8]});
    wr(IDX_VAL_LO, d[7:0]);
    wr(IDX_CTRL, ct);
    wr(IDX_UNLOCK, u);
    wr(IDX_UNLOCK, UNLOCK_B);
    wr(IDX_CTRL, ct | 8'h02);
  endtask

  // Drop permit mid-write, then see done set and go cleared
  task automatic finish_long();
    wr(IDX_CTRL, 8'h80);
    wait (halt === 1'b1);
    wait (halt === 1'b0);
    @(posedge clk);
    rd(IDX_FLAGS2, 8'h10, 8'h10);
    rd(IDX_CTRL, 8'h00, 8'h02);
    wr(IDX_FLAGS2, 8'h00);
    rd(IDX_FLAGS2, 8'h00, 8'h10);
  endtask

  initial begin
    void'($urandom(35));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(IDX_CTRL, 8'h00, 8'h04);
    word_go(12'h003, 14'h0123, 8'h84, UNLOCK_A);
    rd(IDX_CTRL, 8'h00, 8'h0a);
    repeat (POR) @(posedge clk);
    rd(IDX_FLAGS2, FLAGS2_RST, 8'hff);
    rd(IDX_ENABLE2, ENABLE2_RST, 8'hff);
    rd(IDX_CONFIG, CONFIG_RST, 8'hff);
    rd(IDX_UNLOCK, 8'h00, 8'hff);
    rd(9'h1ff, 8'h00, 8'hff, RESP_SLVERR);
    wr(9'h1ff, 8'h5a, RESP_SLVERR);
    foreach (bad_ctl[i]) begin
      word_go(12'h013, 14'h0456, bad_ctl[i], bad_ul[i]);
      rd(IDX_CTRL, 8'h00, 8'h02);
    end
    blk = 10'($urandom);
    slow <= 1'($urandom);
    for (int i = 0; i < 4; i++) wd.word[i] = 14'($urandom);
    fq.push_back({blk, wd});
    for (int i = 0; i < 4; i++) begin
      word_go({blk, 2'(i)}, wd.word[i], 8'h84, UNLOCK_A);
      if (i < 3) rd(IDX_CTRL, 8'h00, 8'h02);
    end
    finish_long();
    // Only the last slot is loaded, so the others must be blank in the block commit
    for (int s = 0; s < 4; s++) begin
      wr(IDX_CONFIG, 8'(s));
      if (s == 3) fq.push_back({10'h03f, 14'h0aaa, {3{BLANK_WORD}}});
      word_go(12'h0ff, 14'h0aaa, 8'h84, UNLOCK_A);
      if (s == 3) finish_long();
      else rd(IDX_CTRL, 8'h08, 8'h0a);
    end
    repeat (8) begin
      c = 2'($urandom);
      x = 3'($urandom) | 3'b100;
      wr(IDX_CONFIG, {4'h0, c, 2'b11});
      eq.push_back(((c[0] && (!x[0] || x[1])) || (c[1] && x[0])) ? 2'b01 : 2'b10);
      ext <= x;
      @(posedge clk);
      ext <= '0;
      repeat (2) @(posedge clk);
    end
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
